// >>> hw/ask_consts.vh
// constants for the accessory switch and key control block
// assumes a 20 MHz core clock and a plain word-indexed register port
`ifndef ASK_CONSTS_VH
`define ASK_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASK_CLK_HZ 20000000
`define ASK_MS_CYCLES (`ASK_CLK_HZ / 1000)
`define ASK_DEBOUNCE_MS 20
`define ASK_PSAVE_SAMPLE_MS 5
`define ASK_SHORT_PRESS_MS 300
`define ASK_LONG_PRESS_MS 1000
`define ASK_OVP_OFF_NS 1000
`define ASK_OTP_MAX_TRIPS 3'h7
`define ASK_BUTTONS 13

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define ASK_REG_CTRL 3'h0
`define ASK_REG_MANSW 3'h1
`define ASK_REG_INT1 3'h2
`define ASK_REG_INT2 3'h3
`define ASK_REG_BTN1 3'h4
`define ASK_REG_BTN2 3'h5
`define ASK_REG_TIMING 3'h6
`define ASK_REG_STATUS 3'h7

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define ASK_CTRL_SWITCH_OPEN 0
`define ASK_CTRL_AUTO_SWITCH 1
`define ASK_CTRL_ALLOW 2
`define ASK_CTRL_RAW_DATA 3
`define ASK_CTRL_AUTO_PSAVE 4
`define ASK_CTRL_PSAVE 5
`define ASK_CTRL_RST 6'h1f
`define ASK_MANSW_RST 13'h0000
// timing: [7:0] wake-up period in ms, [15:8] idle time in 100 ms units
`define ASK_TIMING_RST 16'h6432
`define ASK_IDLE_UNIT_MS 100

// ----------------------------------------------------------------
// interrupt bit positions
// ----------------------------------------------------------------
`define ASK_INT1_DETACH 0
`define ASK_INT1_SHORT_PRESS 1
`define ASK_INT1_OVERVOLTAGE 2
`define ASK_INT1_OVERTEMP 3
`define ASK_INT1_RELEASED 4
`define ASK_INT2_LONG_PRESS 0
`define ASK_INT2_LONG_RELEASE 1
`define ASK_INT2_ADC_CHANGE 2
`define ASK_BTN2_UNKNOWN 5
`define ASK_BTN2_ERROR 6

// ----------------------------------------------------------------
// accessory types and modes
// ----------------------------------------------------------------
`define ASK_ACC_NONE 4'h0
`define ASK_ACC_AUDIO 4'h1
`define ASK_ACC_USB 4'h2
`define ASK_ACC_UART 4'h3
`define ASK_ACC_USB_CHG 4'h4
`define ASK_ACC_DED_CHG 4'h5
`define ASK_ACC_5W1_CHG 4'h6
`define ASK_ACC_5W2_CHG 4'h7
`define ASK_ACC_JUSB_OFF 4'h8
`define ASK_ACC_JUSB_ON 4'h9
`define ASK_ACC_JUART_OFF 4'ha
`define ASK_ACC_JUART_ON 4'hb
`define ASK_ACC_TTY 4'hc
`define ASK_ACC_UNK_PWR 4'hd
`define ASK_MODE_STANDBY 2'h0
`define ASK_MODE_ACTIVE 2'h1
`define ASK_MODE_PSAVE 2'h2

`endif

// >>> hw/ask_ctrl.v
// switch, pass transistor, protection, key and power-save control
// assumes identification and adc logic on clk; analog flags are async
//
// Chosen here: the placing of the registers and the strobed register port.
`include "ask_consts.vh"

module ask_ctrl #(
    parameter MS_CYCLES = `ASK_MS_CYCLES,
    parameter DEBOUNCE_MS = `ASK_DEBOUNCE_MS,
    parameter PSAVE_SAMPLE_MS = `ASK_PSAVE_SAMPLE_MS,
    parameter SHORT_PRESS_MS = `ASK_SHORT_PRESS_MS,
    parameter LONG_PRESS_MS = `ASK_LONG_PRESS_MS,
    parameter IDLE_UNIT_MS = `ASK_IDLE_UNIT_MS
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // identification and adc, same clock
    input wire acc_valid,
    input wire [3:0] acc_type,
    input wire [4:0] adc_result,
    // analog flags, asynchronous
    input wire overvoltage_in,
    input wire overtemp_in,
    input wire identification_line_open,
    input wire key_in,
    input wire switch_activity_in,
    input wire core_below_por_in,
    input wire bus_in_range_in,
    // switches, bit n-1 is switch n
    output reg [9:0] sw_on,
    output reg pass_transistor_block,
    // pins
    output reg charge_current_select_o,
    output reg charge_current_select_oe_n,
    output reg jig_oe_n,
    output reg boot_o,
    output reg host_interrupt_n
);

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
reg [6:0] meta_r;
reg [6:0] sync_r;
wire ovp_s = sync_r[0];
wire otp_s = sync_r[1];
wire idopen_s = sync_r[2];
wire key_s = sync_r[3];
wire act_s = sync_r[4];
wire por_low_s = sync_r[5];
wire bus_ok_s = sync_r[6];

always @(posedge clk)
begin
    if (rst)
    begin
        // id line idles open, so no false detach edge after reset
        meta_r <= 7'h04;
        sync_r <= 7'h04;
    end
    else
    begin
        meta_r <= {bus_in_range_in, core_below_por_in, switch_activity_in, key_in,
            identification_line_open, overtemp_in, overvoltage_in};
        sync_r <= meta_r;
    end
end

// ----------------------------------------------------------------
// millisecond tick
// ----------------------------------------------------------------
reg [15:0] div_r;
reg ms_tick_r;

always @(posedge clk)
begin
    if (rst || div_r == MS_CYCLES[15:0] - 16'h0001)
        div_r <= 16'h0000;
    else
        div_r <= div_r + 16'h0001;
    ms_tick_r <= !rst && div_r == MS_CYCLES[15:0] - 16'h0001;
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [5:0] ctrl_r;
reg [12:0] mansw_r;
reg [4:0] int1_r;
reg [2:0] int2_r;
reg [7:0] btn1_r;
reg [6:0] btn2_r;
reg [15:0] timing_r;
reg [1:0] mode_r;
reg [3:0] type_r;
reg [2:0] otp_trips_r;

wire switch_open = ctrl_r[`ASK_CTRL_SWITCH_OPEN];
wire auto_switch = ctrl_r[`ASK_CTRL_AUTO_SWITCH];
wire allow = ctrl_r[`ASK_CTRL_ALLOW];
wire raw_data = ctrl_r[`ASK_CTRL_RAW_DATA];
wire auto_psave = ctrl_r[`ASK_CTRL_AUTO_PSAVE];
wire wr_hit_ctrl = reg_wr && reg_addr == `ASK_REG_CTRL;
wire rd_int1 = reg_rd && reg_addr == `ASK_REG_INT1;
wire rd_int2 = reg_rd && reg_addr == `ASK_REG_INT2;
wire rd_btn1 = reg_rd && reg_addr == `ASK_REG_BTN1;
wire rd_btn2 = reg_rd && reg_addr == `ASK_REG_BTN2;

// event pulses from the logic below
reg [4:0] int1_set;
reg [2:0] int2_set;
reg [7:0] btn1_set;
reg [6:0] btn2_set;
reg err_clr;

always @(posedge clk)
begin
    if (rst)
    begin
        ctrl_r <= `ASK_CTRL_RST;
        mansw_r <= `ASK_MANSW_RST;
        timing_r <= `ASK_TIMING_RST;
        int1_r <= 5'h00;
        int2_r <= 3'h0;
        btn1_r <= 8'h00;
        btn2_r <= 7'h00;
        reg_rdata <= 16'h0000;
    end
    else
    begin
        if (wr_hit_ctrl)
            ctrl_r <= reg_wdata[5:0];
        if (reg_wr && reg_addr == `ASK_REG_MANSW)
            mansw_r <= reg_wdata[12:0];
        if (reg_wr && reg_addr == `ASK_REG_TIMING)
            timing_r <= reg_wdata;
        // read clears, a coinciding set wins
        int1_r <= (int1_r & ~{5{rd_int1}}) | int1_set;
        int2_r <= (int2_r & ~{3{rd_int2}}) | int2_set;
        btn1_r <= (btn1_r & ~{8{rd_btn1}}) | btn1_set;
        btn2_r <= (btn2_r & ~{7{rd_btn2}}
            & ~({6'h00, err_clr} << `ASK_BTN2_ERROR)) | btn2_set;
        if (reg_rd)
        begin
            case (reg_addr)
                `ASK_REG_CTRL: reg_rdata <= {10'h000, ctrl_r};
                `ASK_REG_MANSW: reg_rdata <= {3'h0, mansw_r};
                `ASK_REG_INT1: reg_rdata <= {11'h000, int1_r};
                `ASK_REG_INT2: reg_rdata <= {13'h0000, int2_r};
                `ASK_REG_BTN1: reg_rdata <= {8'h00, btn1_r};
                `ASK_REG_BTN2: reg_rdata <= {9'h000, btn2_r};
                `ASK_REG_TIMING: reg_rdata <= timing_r;
                default: reg_rdata <= {7'h00, otp_trips_r, type_r, mode_r};
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end
end

// ----------------------------------------------------------------
// wake-up, idle and power-save sampling timers
// ----------------------------------------------------------------
reg [7:0] wake_ms_r;
reg [2:0] samp_ms_r;
reg [15:0] idle_ms_r;
wire wake_tick = ms_tick_r && wake_ms_r >= timing_r[7:0];
wire samp_tick = ms_tick_r && samp_ms_r == PSAVE_SAMPLE_MS[2:0] - 3'h1;
wire idle_done = idle_ms_r >= timing_r[15:8] * IDLE_UNIT_MS[7:0];
wire audio_like = type_r == `ASK_ACC_AUDIO || type_r == `ASK_ACC_TTY;
wire in_psave = mode_r == `ASK_MODE_PSAVE;

always @(posedge clk)
begin
    if (rst || wake_tick)
        wake_ms_r <= 8'h00;
    else if (ms_tick_r)
        wake_ms_r <= wake_ms_r + 8'h01;
    if (rst || samp_tick)
        samp_ms_r <= 3'h0;
    else if (ms_tick_r)
        samp_ms_r <= samp_ms_r + 3'h1;
    if (rst || act_s || mode_r != `ASK_MODE_ACTIVE)
        idle_ms_r <= 16'h0000;
    else if (ms_tick_r && !idle_done)
        idle_ms_r <= idle_ms_r + 16'h0001;
end

// id line watched every cycle when active, at wake ticks in power save
reg idopen_r;
reg key_r;
wire detach = !idopen_r && (in_psave ? (wake_tick && idopen_s) : idopen_s);

always @(posedge clk)
begin
    if (rst)
    begin
        idopen_r <= 1'b1;
        key_r <= 1'b0;
    end
    else
    begin
        if (!in_psave || wake_tick)
            idopen_r <= idopen_s;
        if (!in_psave || samp_tick)
            key_r <= key_s;
    end
end

// ----------------------------------------------------------------
// operating mode
// ----------------------------------------------------------------
always @(posedge clk)
begin
    if (rst)
    begin
        mode_r <= `ASK_MODE_STANDBY;
        type_r <= `ASK_ACC_NONE;
    end
    else
    begin
        case (mode_r)
            `ASK_MODE_STANDBY:
                if (acc_valid && acc_type != `ASK_ACC_NONE)
                begin
                    mode_r <= `ASK_MODE_ACTIVE;
                    type_r <= acc_type;
                end
            `ASK_MODE_ACTIVE:
                if (detach)
                    mode_r <= `ASK_MODE_STANDBY;
                else if (audio_like && auto_psave && idle_done)
                    mode_r <= `ASK_MODE_PSAVE;
                else if (audio_like && !auto_psave && ctrl_r[`ASK_CTRL_PSAVE])
                    mode_r <= `ASK_MODE_PSAVE;
            `ASK_MODE_PSAVE:
                if (detach)
                    mode_r <= `ASK_MODE_STANDBY;
                else if (auto_psave ? act_s : !ctrl_r[`ASK_CTRL_PSAVE])
                    mode_r <= `ASK_MODE_ACTIVE;
            default:
                mode_r <= `ASK_MODE_STANDBY;
        endcase
        if (detach)
            type_r <= `ASK_ACC_NONE;
    end
end

// ----------------------------------------------------------------
// over-voltage and over-temperature
// ----------------------------------------------------------------
reg ovp_r;
reg otp_r;
wire attach = mode_r == `ASK_MODE_STANDBY && acc_valid && acc_type != `ASK_ACC_NONE;
wire otp_lock = otp_trips_r == `ASK_OTP_MAX_TRIPS;

always @(posedge clk)
begin
    if (rst)
    begin
        ovp_r <= 1'b0;
        otp_r <= 1'b0;
        otp_trips_r <= 3'h0;
    end
    else
    begin
        ovp_r <= ovp_s;
        otp_r <= otp_s;
        if (attach)
            otp_trips_r <= 3'h0;
        else if (otp_s && !otp_r && !otp_lock)
            otp_trips_r <= otp_trips_r + 3'h1;
    end
end

// ----------------------------------------------------------------
// remote key timing
// ----------------------------------------------------------------
localparam K_IDLE = 2'h0;
localparam K_DEB = 2'h1;
localparam K_HOLD = 2'h2;
localparam K_LONG = 2'h3;
reg [1:0] kst_r;
reg [15:0] key_ms_r;
reg [4:0] adc_last_r;
reg [4:0] btn_code_r;
wire key_en = raw_data && type_r == `ASK_ACC_AUDIO && mode_r != `ASK_MODE_STANDBY;
wire [15:0] btn_hot = (btn_code_r < `ASK_BUTTONS) ? (16'h0001 << btn_code_r) : 16'h0000;

always @*
begin
    int1_set = 5'h00;
    int2_set = 3'h0;
    btn1_set = 8'h00;
    btn2_set = 7'h00;
    err_clr = 1'b0;
    int1_set[`ASK_INT1_DETACH] = detach;
    int1_set[`ASK_INT1_OVERVOLTAGE] = ovp_s && !ovp_r;
    int1_set[`ASK_INT1_OVERTEMP] = otp_s && !otp_r;
    int1_set[`ASK_INT1_RELEASED] = (ovp_r && !ovp_s)
        || (otp_r && !otp_s && !otp_lock);
    int2_set[`ASK_INT2_ADC_CHANGE] = !raw_data && type_r == `ASK_ACC_AUDIO
        && wake_tick && adc_result != adc_last_r;
    if (kst_r == K_IDLE && key_en && key_r)
        err_clr = 1'b1;
    if ((kst_r == K_HOLD && !key_r && key_ms_r >= SHORT_PRESS_MS[15:0])
        || (kst_r == K_HOLD && key_r && key_ms_r >= LONG_PRESS_MS[15:0]))
    begin
        btn1_set = btn_hot[7:0];
        btn2_set[4:0] = btn_hot[12:8];
        btn2_set[`ASK_BTN2_UNKNOWN] = btn_hot[12:0] == 13'h0000;
    end
    if (kst_r == K_HOLD && !key_r)
    begin
        int1_set[`ASK_INT1_SHORT_PRESS] = 1'b1;
        btn2_set[`ASK_BTN2_ERROR] = key_ms_r < SHORT_PRESS_MS[15:0];
    end
    if (kst_r == K_HOLD && key_r && key_ms_r >= LONG_PRESS_MS[15:0])
        int2_set[`ASK_INT2_LONG_PRESS] = 1'b1;
    if (kst_r == K_LONG && !key_r)
        int2_set[`ASK_INT2_LONG_RELEASE] = 1'b1;
end

always @(posedge clk)
begin
    if (rst)
    begin
        kst_r <= K_IDLE;
        key_ms_r <= 16'h0000;
        adc_last_r <= 5'h00;
        btn_code_r <= 5'h00;
    end
    else
    begin
        if (wake_tick)
            adc_last_r <= adc_result;
        if (ms_tick_r)
            key_ms_r <= key_ms_r + 16'h0001;
        case (kst_r)
            K_IDLE:
                if (key_en && key_r)
                begin
                    kst_r <= K_DEB;
                    key_ms_r <= 16'h0000;
                end
            K_DEB:
                if (!key_r || !key_en)
                    kst_r <= K_IDLE;
                else if (key_ms_r >= DEBOUNCE_MS[15:0])
                begin
                    kst_r <= K_HOLD;
                    key_ms_r <= 16'h0000;
                    // code taken while held; it is gone by release
                    btn_code_r <= adc_result;
                end
            K_HOLD:
                if (!key_r)
                    kst_r <= K_IDLE;
                else if (key_ms_r >= LONG_PRESS_MS[15:0])
                    kst_r <= K_LONG;
            K_LONG:
                if (!key_r)
                    kst_r <= K_IDLE;
            default:
                kst_r <= K_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// switch map and outputs
// ----------------------------------------------------------------
function [9:0] auto_map;
    input [3:0] t;
    begin
        case (t)
            `ASK_ACC_AUDIO, `ASK_ACC_TTY: auto_map = 10'h258;
            `ASK_ACC_USB, `ASK_ACC_JUSB_OFF, `ASK_ACC_JUSB_ON: auto_map = 10'h0a4;
            `ASK_ACC_UART, `ASK_ACC_JUART_OFF, `ASK_ACC_JUART_ON: auto_map = 10'h203;
            `ASK_ACC_USB_CHG: auto_map = 10'h1a4;
            `ASK_ACC_DED_CHG: auto_map = 10'h180;
            `ASK_ACC_5W1_CHG, `ASK_ACC_5W2_CHG: auto_map = 10'h080;
            default: auto_map = 10'h000;
        endcase
    end
endfunction

wire block = !auto_switch || !switch_open || type_r == `ASK_ACC_UNK_PWR || !allow;
wire standby = mode_r == `ASK_MODE_STANDBY;
wire [9:0] sel = auto_switch ? auto_map(type_r) : mansw_r[9:0];
wire charger = type_r == `ASK_ACC_USB_CHG || type_r == `ASK_ACC_DED_CHG;
wire jig = type_r >= `ASK_ACC_JUSB_OFF && type_r <= `ASK_ACC_JUART_ON;
reg [9:0] sw_nxt;

always @*
begin
    sw_nxt = (standby || !switch_open) ? 10'h000 : sel;
    sw_nxt[7] = (!standby && sel[7] && switch_open && !block && !ovp_s
        && !otp_s && !otp_lock) || (por_low_s && bus_ok_s);
    sw_nxt[9] = sw_nxt[9] || !allow;
end

always @(posedge clk)
begin
    if (rst)
    begin
        sw_on <= 10'h200;
        pass_transistor_block <= 1'b0;
        charge_current_select_o <= 1'b0;
        charge_current_select_oe_n <= 1'b1;
        jig_oe_n <= 1'b1;
        boot_o <= 1'b0;
        host_interrupt_n <= 1'b1;
    end
    else
    begin
        sw_on <= sw_nxt;
        pass_transistor_block <= block;
        charge_current_select_o <= 1'b0;
        host_interrupt_n <= int1_r == 5'h00 && int2_r == 3'h0;
        if (standby)
        begin
            charge_current_select_oe_n <= 1'b1;
            jig_oe_n <= 1'b1;
            boot_o <= 1'b0;
        end
        else if (!auto_switch)
        begin
            charge_current_select_oe_n <= !mansw_r[10];
            jig_oe_n <= !mansw_r[11];
            boot_o <= mansw_r[12];
        end
        else
        begin
            charge_current_select_oe_n <= !charger;
            jig_oe_n <= !jig;
            boot_o <= type_r == `ASK_ACC_JUSB_ON || type_r == `ASK_ACC_JUART_ON;
        end
    end
end

endmodule // ask_ctrl

// >>> sim/ask_acc_model.sv
// accessory side model: identification result, id line, key comparator
// assumes the bench plugs, picks the type and presses keys
module ask_acc_model #(
    parameter logic [2:0] ID_DLY = 3'h3
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // bench commands
    input wire plug,
    input wire [3:0] ptype,
    input wire key,
    input wire [4:0] kcode,
    // towards the block
    output logic acc_valid,
    output logic [3:0] acc_type,
    output wire [4:0] adc_result,
    output wire identification_line_open,
    output wire key_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    // unplugged line floats; idle code without a press
    assign identification_line_open = !plug;
    assign adc_result = key ? kcode : 5'h1f;
    assign key_in = key;
    always @(posedge clk)
    begin
        if (rst || !plug)
        begin
            cnt <= 3'h0;
            acc_valid <= 1'b0;
            // type is meaningless here, so it keeps changing
            acc_type <= rst ? 4'h0 : ~acc_type;
        end
        else
        begin
            if (cnt != ID_DLY)
                cnt <= cnt + 3'h1;
            acc_valid <= cnt == ID_DLY;
            acc_type <= ptype;
        end
    end
endmodule // ask_acc_model

// >>> sim/ask_ctrl_asserts.sv
// checker for the accessory switch and key control block
// assumes it is bound onto ask_ctrl and sees only its ports
module ask_ctrl_asserts (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    // analog flags
    input wire overvoltage_in,
    input wire overtemp_in,
    input wire identification_line_open,
    input wire core_below_por_in,
    input wire bus_in_range_in,
    // outputs
    input wire [9:0] sw_on,
    input wire pass_transistor_block,
    input wire charge_current_select_oe_n,
    input wire jig_oe_n,
    input wire boot_o,
    input wire host_interrupt_n
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [5:0] ctrl_r;
    reg int_rd_r;
    reg [10:0] open_cnt_r;
    reg [3:0] por_hist_r;
    wire por_path = core_below_por_in && bus_in_range_in;
    // forced supply path overrides the pass transistor, so keep clear of it
    wire por_quiet = !por_path && por_hist_r == 4'h0;
    // ----
    // helper state
    // ----
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= 6'h1f;
            int_rd_r <= 1'b0;
            open_cnt_r <= 11'h000;
            por_hist_r <= 4'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == 3'h0)
                ctrl_r <= reg_wdata[5:0];
            int_rd_r <= reg_rd && (reg_addr == 3'h2 || reg_addr == 3'h3);
            por_hist_r <= {por_hist_r[2:0], por_path};
            // 1100 cycles covers one wake interval of the bench
            if (!identification_line_open)
                open_cnt_r <= 11'h000;
            else if (open_cnt_r != 11'h44c)
                open_cnt_r <= open_cnt_r + 11'h001;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----
    // properties
    // ----
    property p_gnd;
        (!ctrl_r[2]) [*3] |-> sw_on[9];
    endproperty
    a_gnd: assert property (p_gnd)
        else $error("ground fet open while pass disallowed");
    property p_blk;
        (!ctrl_r[0] || !ctrl_r[1] || !ctrl_r[2]) [*3] |-> pass_transistor_block;
    endproperty
    a_blk: assert property (p_blk)
        else $error("block signal low under a blocking setting");
    property p_pass;
        pass_transistor_block && $past(pass_transistor_block) && por_quiet |-> !sw_on[7];
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass transistor on while blocked");
    property p_ovp;
        (overvoltage_in && por_quiet) [*4] |-> !sw_on[7];
    endproperty
    a_ovp: assert property (p_ovp)
        else $error("pass transistor on during overvoltage");
    property p_otp;
        (overtemp_in && por_quiet) [*8] |-> !sw_on[7];
    endproperty
    a_otp: assert property (p_otp)
        else $error("pass transistor on during overtemperature");
    property p_por;
        por_path [*4] |-> sw_on[7];
    endproperty
    a_por: assert property (p_por)
        else $error("pass transistor off on the forced supply path");
    property p_det;
        open_cnt_r == 11'h44c && por_quiet |->
            sw_on[8:0] == 9'h000 && jig_oe_n && charge_current_select_oe_n && !boot_o;
    endproperty
    a_det: assert property (p_det)
        else $error("standby outputs wrong with id line open");
    property p_rdz;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rdz: assert property (p_rdz)
        else $error("read data outside the read answer cycle");
    property p_int;
        int_rd_r && reg_rdata != 16'h0000 |-> !host_interrupt_n;
    endproperty
    a_int: assert property (p_int)
        else $error("interrupt line high with a pending bit");
    c_ovp: cover property (overvoltage_in && !sw_on[7]);
    c_det: cover property (open_cnt_r == 11'h44c);
    c_int: cover property ($fell(host_interrupt_n));
endmodule // ask_ctrl_asserts

bind ask_ctrl ask_ctrl_asserts u_chk (.*);

// >>> sim/ask_ctrl_tb.sv
// self-checking bench for the accessory switch and key control block
// assumes ask_ctrl with 1 ms = 20 cycles and short press counts
module ask_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, overvoltage_in = 1'b0, overtemp_in = 1'b0;
    logic switch_activity_in = 1'b0, core_below_por_in = 1'b0, bus_in_range_in = 1'b0;
    logic plug = 1'b0, key = 1'b0;
    logic [3:0] ptype = 4'h0;
    logic [4:0] kcode = 5'h00;
    wire acc_valid, identification_line_open, key_in, pass_transistor_block;
    wire charge_current_select_o, charge_current_select_oe_n, jig_oe_n, boot_o;
    wire host_interrupt_n;
    wire [3:0] acc_type;
    wire [4:0] adc_result;
    wire [15:0] reg_rdata;
    wire [9:0] sw_on;
    int error_cnt = 0, checked = 0, i;

    ask_ctrl #(.MS_CYCLES(20), .SHORT_PRESS_MS(3), .LONG_PRESS_MS(6), .IDLE_UNIT_MS(1)) uut (.*);
    ask_acc_model acc (.*);

    initial
    begin
        forever #25 clk = ~clk;
    end
    // ----
    // tasks
    // ----
    task give_verdict;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
        @(posedge clk);
    endtask
    // bounded wait for a switch pattern; a miss ends the run
    task ws(input logic [9:0] m, input logic [9:0] e, input int n);
        int k;
        @(negedge clk);
        for (k = 0; k < n && (sw_on & m) !== e; k++)
            @(negedge clk);
        chk({6'h00, sw_on & m}, {6'h00, e});
        if ((sw_on & m) !== e)
            give_verdict;
        @(posedge clk);
    endtask
    function automatic logic [9:0] mp(input logic [3:0] t);
        case (t)
            4'h1, 4'hc: mp = 10'h258;
            4'h2, 4'h8, 4'h9: mp = 10'h0a4;
            4'h3, 4'ha, 4'hb: mp = 10'h203;
            4'h4: mp = 10'h1a4;
            4'h5: mp = 10'h180;
            default: mp = 10'h080;
        endcase
    endfunction
    task att(input logic [3:0] t);
        ptype <= t;
        plug <= 1'b1;
        ws(10'h3ff, mp(t), 50);
    endtask
    task det;
        plug <= 1'b0;
        cyc(4);
        ws(10'h1ff, 10'h000, 1200);
        rd(3'h2, 16'hffff, 16'h0001);
    endtask
    task kt(input int n, input logic [4:0] c, input logic [15:0] i1, i2, b1, b2);
        kcode <= c;
        key <= 1'b1;
        cyc(n);
        key <= 1'b0;
        cyc(60);
        #1 chk({15'h0000, host_interrupt_n}, {15'h0000, i1 == 0 && i2 == 0});
        rd(3'h2, 16'hffff, i1);
        rd(3'h3, 16'hffff, i2);
        rd(3'h4, 16'hffff, b1);
        rd(3'h5, 16'hffff, b2);
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        cyc(12);
        rst <= 1'b0;
        @(posedge clk);
        rd(3'h0, 16'hffff, 16'h001f);
        rd(3'h1, 16'hffff, 16'h0000);
        rd(3'h6, 16'hffff, 16'h6432);
        wr(3'h2, 16'hffff);
        rd(3'h2, 16'hffff, 16'h0000);
        rd(3'h7, 16'h0003, 16'h0000);
        #1 chk({13'h0000, jig_oe_n, charge_current_select_oe_n, boot_o}, 16'h0006);
        chk({6'h00, sw_on & 10'h1ff}, 16'h0000);
        for (i = 1; i < 13; i++)
        begin
            att(i[3:0]);
            #1 chk({15'h0000, pass_transistor_block}, 16'h0000);
            chk({12'h000, jig_oe_n, charge_current_select_oe_n, boot_o,
                charge_current_select_o}, {12'h000, !(i > 7 && i < 12), !(i == 4 || i == 5),
                i == 9 || i == 11, 1'b0});
            det;
        end
        ptype <= 4'hd;
        plug <= 1'b1;
        cyc(10);
        #1 chk({15'h0000, pass_transistor_block}, 16'h0001);
        det;
        att(4'h4);
        wr(3'h1, 16'h000f);
        wr(3'h0, 16'h001d);
        ws(10'h3ff, 10'h00f, 10);
        #1 chk({15'h0000, pass_transistor_block}, 16'h0001);
        wr(3'h0, 16'h001f);
        ws(10'h3ff, 10'h1a4, 10);
        wr(3'h0, 16'h001e);
        ws(10'h1ff, 10'h000, 10);
        wr(3'h0, 16'h001b);
        ws(10'h3ff, 10'h324, 10);
        wr(3'h0, 16'h001f);
        ws(10'h3ff, 10'h1a4, 10);
        overvoltage_in <= 1'b1;
        ws(10'h080, 10'h000, 20);
        cyc(3);
        #1 chk({15'h0000, host_interrupt_n}, 16'h0000);
        rd(3'h2, 16'hffff, 16'h0004);
        overvoltage_in <= 1'b0;
        ws(10'h3ff, 10'h1a4, 20);
        cyc(3);
        rd(3'h2, 16'hffff, 16'h0010);
        for (i = 0; i < 7; i++)
        begin
            overtemp_in <= 1'b1;
            ws(10'h080, 10'h000, 50);
            overtemp_in <= 1'b0;
            cyc(10);
            #1 chk({15'h0000, sw_on[7]}, {15'h0000, i < 6});
        end
        rd(3'h2, 16'hffff, 16'h0018);
        det;
        core_below_por_in <= 1'b1;
        bus_in_range_in <= 1'b1;
        ws(10'h080, 10'h080, 10);
        core_below_por_in <= 1'b0;
        bus_in_range_in <= 1'b0;
        att(4'h4);
        det;
        wr(3'h6, 16'h0204);
        att(4'h1);
        cyc(100);
        rd(3'h7, 16'h003f, 16'h0006);
        switch_activity_in <= 1'b1;
        cyc(4);
        rd(3'h7, 16'h0003, 16'h0001);
        switch_activity_in <= 1'b0;
        wr(3'h0, 16'h000f);
        cyc(60);
        rd(3'h7, 16'h0003, 16'h0001);
        wr(3'h0, 16'h002f);
        rd(3'h7, 16'h0003, 16'h0002);
        det;
        wr(3'h0, 16'h000f);
        att(4'h1);
        kt(200, 5'h02, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        kt(430, 5'h02, 16'h0002, 16'h0000, 16'h0000, 16'h0040);
        kt(480, 5'h02, 16'h0002, 16'h0000, 16'h0004, 16'h0000);
        kt(480, 5'h14, 16'h0002, 16'h0000, 16'h0000, 16'h0020);
        kt(580, 5'h0a, 16'h0000, 16'h0003, 16'h0000, 16'h0004);
        wr(3'h0, 16'h0007);
        kcode <= 5'h03;
        key <= 1'b1;
        cyc(300);
        rd(3'h3, 16'hffff, 16'h0004);
        rd(3'h2, 16'hffff, 16'h0000);
        key <= 1'b0;
        det;
        give_verdict;
    end
endmodule // ask_ctrl_tb
